// [rtl/urs_map.svh]
`ifndef URS_MAP_SVH
`define URS_MAP_SVH
// register byte offsets
`define URS_CTRL_OFS 4'h0
`define URS_STAT_OFS 4'h4
`define URS_BUF_ADDR_OFS 4'h8
`define URS_BUF_DATA_OFS 4'hC
// control bit positions
`define URS_CTRL_ENABLE_BIT 0
`define URS_CTRL_FREEZE_BIT 1
`define URS_CTRL_HOST_SEL_BIT 2
// status bit positions
`define URS_STAT_ROLE_BIT 0
`define URS_STAT_DEV_RUN_BIT 1
`define URS_STAT_HOST_RUN_BIT 2
`define URS_STAT_STATE_LSB 3
// reset values
`define URS_CTRL_RESET 3'h2
// buffer, endpoint and PLL clock figures
`define URS_BUF_BYTES 2368
`define URS_EP_COUNT 7
`define URS_EP_CTRL_SIZE 64
`define URS_EP_BIG_SIZE 512
`define URS_EP_BIG_COUNT 2
`define URS_EP_SMALL_SIZE 64
`define URS_PLL_MHZ 480
`endif

// [rtl/urs_pkg.sv]
`default_nettype none
package urs_pkg;
  typedef enum logic [1:0] {URS_RESET, URS_DEVICE, URS_HOST} urs_state_t;
endpackage
`default_nettype wire

// [rtl/urs_role_select.sv]
// Functional notes
// [RQ1] after hardware reset the controller stays disabled until software enables it
// [RQ2] when enabled, exactly one of device or host controller runs, chosen by role pin
// [RQ3] role pin high (pulled up) sets role status and selects device controller
// [RQ4] role pin low clears role status, disables device, enables host controller
// [RQ5] host-select bit picks which shared register set software reaches, regardless of role
// [RQ6] in reset state enable reads 0, freeze reads 1, macro clock stopped
// [RQ7] in reset state macro disabled and pad suspended
// [RQ8] entering reset state returns host and device state machines to idle
// [RQ9] provide a 2368-byte dual-port buffer memory for endpoints and pipes
// [RQ10] up to 7 endpoints: 64-byte control, two up to 512, four up to 64
// [RQ11] device supports full and high speed; host full speed only
// [RQ12] high speed clocked from the 480 MHz PLL clock
// [RQ13] setting enable enters host or device state by pad level, controller idle
// [RQ14] clearing enable at any time stops the controller like a hardware reset
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`include "urs_map.svh"
`default_nettype none
module urs_role_select
  import urs_pkg::*;
#(
  parameter int BUF_BYTES = `URS_BUF_BYTES,
  parameter int EP_COUNT = `URS_EP_COUNT
)(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pad and pll
  input wire logic role_detect_pad,
  input wire logic pll_480_locked,
  // macro control
  output logic macro_clock_run,
  output logic macro_enable,
  output logic pad_suspend,
  output logic device_ctrl_enable,
  output logic host_ctrl_enable,
  output logic host_regs_select,
  output logic high_speed_allowed,
  output logic ctrl_sm_reset
);
  localparam int AW = $clog2(BUF_BYTES);
  localparam logic [2:0] CTRL_RST = `URS_CTRL_RESET;

  logic [7:0] endpoint_buffer_ram [0:BUF_BYTES-1];
  urs_state_t state_reg, state_next;
  logic enable_reg, freeze_reg, host_sel_reg;
  logic [AW-1:0] buf_addr_reg;
  logic [7:0] buf_rdata_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  function automatic logic [AW-1:0] buf_wrap(input logic [AW-1:0] a);
    buf_wrap = (a >= AW'(BUF_BYTES - 1)) ? '0 : a + AW'(1);
  endfunction

  // per-endpoint size limit, index 0 is the control endpoint
  function automatic int ep_max_bytes(input int idx);
    if (idx == 0)
      ep_max_bytes = `URS_EP_CTRL_SIZE;
    else if (idx <= `URS_EP_BIG_COUNT)
      ep_max_bytes = `URS_EP_BIG_SIZE;
    else
      ep_max_bytes = `URS_EP_SMALL_SIZE;
  endfunction

  function automatic int ep_single_bank_total(input int count);
    ep_single_bank_total = 0;
    for (int i = 0; i < count; i++)
      ep_single_bank_total += ep_max_bytes(i);
  endfunction

  localparam int EP_MIN_BYTES = ep_single_bank_total(EP_COUNT); // RQ10

  wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr = req & wb_we_i & wb_sel_i[0];
  wire logic hit_ctrl = wb_adr_i == `URS_CTRL_OFS;
  wire logic hit_stat = wb_adr_i == `URS_STAT_OFS;
  wire logic hit_addr = wb_adr_i == `URS_BUF_ADDR_OFS;
  wire logic hit_data = wb_adr_i == `URS_BUF_DATA_OFS;
  wire logic role_high = role_detect_pad; // RQ3
  wire logic run = state_reg != URS_RESET;
  wire logic [31:0] ctrl_rd = {29'h0, host_sel_reg, freeze_reg, enable_reg};
  wire logic [31:0] stat_rd = {27'h0, state_reg, state_reg == URS_HOST, state_reg == URS_DEVICE, role_high};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd :
    hit_addr ? 32'(buf_addr_reg) : hit_data ? {24'h0, buf_rdata_reg} : 32'h0;

  // state follows enable and role pin
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      URS_RESET: if (enable_reg) state_next = role_high ? URS_DEVICE : URS_HOST; // RQ13
      URS_DEVICE, URS_HOST:
        if (!enable_reg) state_next = URS_RESET; // RQ14
        else state_next = role_high ? URS_DEVICE : URS_HOST; // RQ2 RQ4
      default: state_next = URS_RESET;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg <= URS_RESET; // RQ1
      enable_reg <= CTRL_RST[`URS_CTRL_ENABLE_BIT];
      freeze_reg <= CTRL_RST[`URS_CTRL_FREEZE_BIT]; // RQ6
      host_sel_reg <= CTRL_RST[`URS_CTRL_HOST_SEL_BIT];
    end
    else
    begin
      state_reg <= state_next;
      if (wr && hit_ctrl)
      begin
        enable_reg <= wb_dat_i[`URS_CTRL_ENABLE_BIT];
        freeze_reg <= wb_dat_i[`URS_CTRL_FREEZE_BIT] | ~wb_dat_i[`URS_CTRL_ENABLE_BIT]; // RQ6 RQ14
        host_sel_reg <= wb_dat_i[`URS_CTRL_HOST_SEL_BIT]; // RQ5
      end
    end
  end

  // direct buffer access, auto increment
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      buf_addr_reg <= '0;
    else if (wr && hit_addr)
      buf_addr_reg <= wb_dat_i < 32'(BUF_BYTES) ? wb_dat_i[AW-1:0] : '0;
    else if (req && hit_data)
      buf_addr_reg <= buf_wrap(buf_addr_reg);
  end

  always_ff @(posedge clock)
  begin
    if (wr && hit_data)
      endpoint_buffer_ram[buf_addr_reg] <= wb_dat_i[7:0]; // RQ9
    buf_rdata_reg <= endpoint_buffer_ram[buf_addr_reg];
  end

  // bus answer, one cycle after request
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= req ? rd_mux : 32'h0;
    end
  end

  // macro control outputs
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      macro_clock_run <= 1'b0;
      macro_enable <= 1'b0;
      pad_suspend <= 1'b1;
      device_ctrl_enable <= 1'b0;
      host_ctrl_enable <= 1'b0;
      host_regs_select <= 1'b0;
      high_speed_allowed <= 1'b0;
      ctrl_sm_reset <= 1'b1;
    end
    else
    begin
      macro_clock_run <= run & ~freeze_reg; // RQ6
      macro_enable <= run; // RQ7
      pad_suspend <= ~run; // RQ7
      device_ctrl_enable <= state_reg == URS_DEVICE; // RQ3
      host_ctrl_enable <= state_reg == URS_HOST; // RQ4
      host_regs_select <= host_sel_reg; // RQ5
      high_speed_allowed <= (state_reg == URS_DEVICE) & pll_480_locked; // RQ11 RQ12
      ctrl_sm_reset <= ~run; // RQ8
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  property p_one_ctrl;
    @(posedge clock) disable iff (!reset_n) !(device_ctrl_enable && host_ctrl_enable);
  endproperty
  a_one_ctrl: assert property (p_one_ctrl) else $error("both controllers enabled"); // RQ2

  property p_dev_role;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_DEVICE |=> device_ctrl_enable;
  endproperty
  a_dev_role: assert property (p_dev_role) else $error("device not enabled"); // RQ3

  property p_host_role;
    @(posedge clock) disable iff (!reset_n) enable_reg && run && !role_high |=> state_reg == URS_HOST;
  endproperty
  a_host_role: assert property (p_host_role) else $error("host not selected on low pad"); // RQ4

  property p_reset_outs;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_RESET |=> pad_suspend && !macro_enable && ctrl_sm_reset;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("reset state outputs wrong"); // RQ7

  property p_clk_stop;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_RESET |=> !macro_clock_run;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("macro clock running in reset"); // RQ6

  sequence s_disable;
    run && !enable_reg;
  endsequence
  property p_stop;
    @(posedge clock) disable iff (!reset_n) s_disable |=> state_reg == URS_RESET ##1 ctrl_sm_reset;
  endproperty
  a_stop: assert property (p_stop) else $error("disable did not stop controller"); // RQ14

  property p_start;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_RESET && enable_reg |=> run;
  endproperty
  a_start: assert property (p_start) else $error("enable did not start controller"); // RQ13

  property p_idle_after_reset;
    @(posedge clock) $rose(reset_n) |-> state_reg == URS_RESET && !enable_reg;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("not disabled after reset"); // RQ1

  property p_hs;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_HOST |=> !high_speed_allowed;
  endproperty
  a_hs: assert property (p_hs) else $error("high speed in host mode"); // RQ11

  property p_freeze_in_reset;
    @(posedge clock) disable iff (!reset_n) !enable_reg |-> freeze_reg;
  endproperty
  a_freeze_in_reset: assert property (p_freeze_in_reset) else $error("freeze clear while disabled"); // RQ6

  property p_ack_answer;
    @(posedge clock) disable iff (!reset_n) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_ack_pulse;
    @(posedge clock) disable iff (!reset_n) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_dat_idle;
    @(posedge clock) disable iff (!reset_n) !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");

  property p_regs_select;
    @(posedge clock) disable iff (!reset_n) host_regs_select == $past(host_sel_reg);
  endproperty
  a_regs_select: assert property (p_regs_select) else $error("register set select wrong"); // RQ5

  property p_sel_hold;
    @(posedge clock) disable iff (!reset_n) !(wr && hit_ctrl) |=> $stable(host_sel_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("host select changed without write"); // RQ5

  property p_hs_device;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_DEVICE && pll_480_locked |=> high_speed_allowed;
  endproperty
  a_hs_device: assert property (p_hs_device) else $error("high speed not allowed in device"); // RQ12

  property p_run_outs;
    @(posedge clock) disable iff (!reset_n) run |=> macro_enable && !pad_suspend && !ctrl_sm_reset;
  endproperty
  a_run_outs: assert property (p_run_outs) else $error("running outputs wrong"); // RQ7 RQ8

  property p_dev_select;
    @(posedge clock) disable iff (!reset_n) enable_reg && role_high |=> state_reg == URS_DEVICE;
  endproperty
  a_dev_select: assert property (p_dev_select) else $error("device not selected on high pad"); // RQ3

  property p_host_out;
    @(posedge clock) disable iff (!reset_n) state_reg == URS_HOST |=> host_ctrl_enable && !device_ctrl_enable;
  endproperty
  a_host_out: assert property (p_host_out) else $error("host outputs wrong"); // RQ4

  property p_buf_range;
    @(posedge clock) disable iff (!reset_n) int'(buf_addr_reg) < BUF_BYTES;
  endproperty
  a_buf_range: assert property (p_buf_range) else $error("buffer address out of range"); // RQ9

  property p_ep_fit;
    @(posedge clock) disable iff (!reset_n) EP_COUNT <= `URS_EP_COUNT && EP_MIN_BYTES <= BUF_BYTES;
  endproperty
  a_ep_fit: assert property (p_ep_fit) else $error("endpoints do not fit buffer"); // RQ10

  sequence s_enable_write;
    wr && hit_ctrl && wb_dat_i[`URS_CTRL_ENABLE_BIT] && !enable_reg;
  endsequence
  property p_enable_walk;
    @(posedge clock) disable iff (!reset_n) s_enable_write |=> enable_reg ##1 run ##1 macro_enable;
  endproperty
  a_enable_walk: assert property (p_enable_walk) else $error("enable did not reach macro"); // RQ13
endmodule
`default_nettype wire

// [test/urs_cable_model.sv]
`default_nettype none
module urs_cable_model (
  // cable side
  input wire logic id_grounded,
  // role pad
  output logic role_detect_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up unless the plug grounds the pin
  assign role_detect_pad = id_grounded ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// [test/urs_role_select_tb.sv]
`include "urs_map.svh"
`default_nettype none
module urs_role_select_tb;
  import urs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, id_grounded = 0, pll_480_locked = 0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, role_detect_pad, macro_clock_run, macro_enable, pad_suspend, device_ctrl_enable;
  logic host_ctrl_enable, host_regs_select, high_speed_allowed, ctrl_sm_reset;
  int err_count = 0, compares = 0;
  int byte_q[$];
  always #4 clock = ~clock;
  urs_cable_model i_cable (.id_grounded(id_grounded), .role_detect_pad(role_detect_pad));
  urs_role_select i_dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .role_detect_pad(role_detect_pad), .pll_480_locked(pll_480_locked),
    .macro_clock_run(macro_clock_run), .macro_enable(macro_enable), .pad_suspend(pad_suspend),
    .device_ctrl_enable(device_ctrl_enable), .host_ctrl_enable(host_ctrl_enable),
    .host_regs_select(host_regs_select), .high_speed_allowed(high_speed_allowed), .ctrl_sm_reset(ctrl_sm_reset));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, read data left in q
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t bus timeout", $time);
      final_report();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask
  // expected macro control outputs
  task automatic outs(input logic en, input logic role);
    chk({macro_enable, pad_suspend, ctrl_sm_reset, macro_clock_run}, {en, !en, !en, en});
    chk({device_ctrl_enable, host_ctrl_enable}, {en & role, en & !role});
    chk(high_speed_allowed, en & role & pll_480_locked);
  endtask
  initial
  begin
    void'($urandom(98648));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    outs(1'b0, 1'b1);
    wb(1'b0, `URS_CTRL_OFS, 32'h0);
    chk(q, `URS_CTRL_RESET);
    for (int r = 0; r < 2; r++)
    begin
      id_grounded <= r[0];
      pll_480_locked <= 1'($urandom);
      wb(1'b1, `URS_CTRL_OFS, {29'h0, !r[0], 2'h1});
      repeat (3) @(posedge clock);
      outs(1'b1, !r[0]);
      chk(host_regs_select, !r[0]);
      wb(1'b0, `URS_STAT_OFS, 32'h0);
      chk(q, {27'h0, r[0] ? 2'h2 : 2'h1, r[0], !r[0], !r[0]});
      wb(1'b1, `URS_CTRL_OFS, 32'h0);
      repeat (3) @(posedge clock);
      outs(1'b0, !r[0]);
      wb(1'b0, `URS_CTRL_OFS, 32'h0);
      chk(q, `URS_CTRL_RESET);
    end
    // hardware reset while running as host
    wb(1'b1, `URS_CTRL_OFS, 32'h5);
    repeat (2) @(posedge clock);
    outs(1'b1, 1'b0);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    outs(1'b0, 1'b0);
    wb(1'b0, `URS_CTRL_OFS, 32'h0);
    chk(q, `URS_CTRL_RESET);
    // last byte then wrap to zero
    byte_q.push_back($urandom % 256);
    byte_q.push_back($urandom % 256);
    wb(1'b1, `URS_BUF_ADDR_OFS, 32'(`URS_BUF_BYTES - 1));
    foreach (byte_q[i]) wb(1'b1, `URS_BUF_DATA_OFS, 32'(byte_q[i]));
    wb(1'b1, `URS_BUF_ADDR_OFS, 32'(`URS_BUF_BYTES - 1));
    while (byte_q.size() > 0)
    begin
      wb(1'b0, `URS_BUF_DATA_OFS, 32'h0);
      chk(q, 32'(byte_q.pop_front()));
    end
    final_report();
  end
endmodule
`default_nettype wire
